//--- logic/wrsi_defines.vh
// Constants for the wake-up and reset state initialiser.
// Assumes inclusion by bare name from design and bench files.
`ifndef WRSI_DEFINES_VH
`define WRSI_DEFINES_VH

// APB byte addresses, one aligned 32-bit word each
`define WRSI_ADDR_STATUS 8'h00
`define WRSI_ADDR_MASK 8'h04
`define WRSI_ADDR_CLASS 8'h08
`define WRSI_ADDR_TOS 8'h0C
`define WRSI_ADDR_SPTR 8'h10
`define WRSI_ADDR_GIE 8'h14
`define WRSI_ADDR_PA_LATCH 8'h18
`define WRSI_ADDR_PA_DIR 8'h1C
`define WRSI_ADDR_PA_PIN 8'h20
`define WRSI_ADDR_WAKE_FLAGS 8'h24

// Event status bit positions
`define WRSI_EV_POWER 0
`define WRSI_EV_EXTERNAL 1
`define WRSI_EV_WAKE 2
`define WRSI_EV_VECTOR 3
`define WRSI_EV_STACK_FULL 4
`define WRSI_EV_W 5

// Global enable bit positions
`define WRSI_GIE_HIGH 0
`define WRSI_GIE_LOW 1

// Reset class codes
`define WRSI_CLASS_NONE 2'h0
`define WRSI_CLASS_POWER 2'h1
`define WRSI_CLASS_EXTERNAL 2'h2
`define WRSI_CLASS_WAKE 2'h3

// Interrupt vector addresses
`define WRSI_VEC_HIGH 21'h000008
`define WRSI_VEC_LOW 21'h000018

// Oscillator mode encodings that keep port A bit 6
`define WRSI_OSC_EXT_IO 4'h5
`define WRSI_OSC_RC_IO 4'h7

// Port A direction reset value and stack pointer constants
`define WRSI_PA_DIR_RST 7'h7F
`define WRSI_SPTR_FULL_BIT 7
`define WRSI_SPTR_TOP 5'h1F

`endif

//--- logic/wrsi_top.v
// Wake-up and reset state initialiser: classifies reset events, sets the
// return stack, vector load and port A bit 6 gating, with an APB slave.
// Assumes reset event inputs come from same-clock logic except the
// external master clear pin and port A pins, which are synchronised here.
// How it works
// - Interrupt wake with enable loads vector
// - Interrupt wake with enable saves PC into stack top
// - Interrupt wake with enable advances return stack pointer
// - Interrupt wake leaves a source flag set
// - Port A bit 6 only in I/O oscillator modes
// - Absent port A bit 6 reads zero
// - Unimplemented bits always read zero
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "wrsi_defines.vh"

module wrsi_top #(
    parameter SRC_W = 8,                    // Wake source flag count
    parameter BIT6_PRESENT = 1              // Port A bit 6 exists
) (
    input wire clock_in,                    // Core clock, 200 MHz
    input wire sys_rst_in,                  // Sync reset, active high
    input wire psel_in,                     // APB select
    input wire penable_in,                  // APB enable
    input wire pwrite_in,                   // APB write
    input wire [7:0] paddr_in,              // APB byte address
    input wire [31:0] pwdata_in,            // APB write data
    output wire [31:0] prdata_out,          // APB read data
    output wire pready_out,                 // APB ready
    output wire pslverr_out,                // APB error, unmapped
    input wire power_on_rst_in,             // Power-on reset level
    input wire brown_out_rst_in,            // Brown-out reset level
    input wire ext_master_clear_n_in,       // Master clear pin, low
    input wire watchdog_rst_in,             // Watchdog reset level
    input wire reset_instr_in,              // Reset instruction
    input wire stack_rst_in,                // Stack over/underflow
    input wire wake_watchdog_in,            // Wake by watchdog
    input wire wake_irq_in,                 // Wake by interrupt
    input wire wake_high_prio_in,           // Wake source is high prio
    input wire [SRC_W-1:0] irq_src_in,      // Sources pending at wake
    input wire [20:0] pc_in,                // Current program counter
    input wire [3:0] osc_mode_in,           // Oscillator configuration
    input wire [6:0] port_a_pin_in,         // Port A pin levels
    output wire pc_load_out,                // Vector load pulse
    output wire [20:0] pc_value_out,        // Vector to load
    output wire [4:0] stack_top_upper_byte_out, // Stack top upper
    output wire [7:0] stack_top_high_byte_out,  // Stack top high
    output wire [7:0] stack_top_low_byte_out,   // Stack top low
    output wire [7:0] return_stack_pointer_out, // Stack pointer
    output wire [SRC_W:0] peripheral_irq_flag_regs_out, // Wake flags
    output wire [1:0] high_low_gie_out,     // Global enables
    output wire [6:0] port_a_output_latch_out, // Port A drive value
    output wire [6:0] port_a_oe_n_out,      // Port A enable, low
    output wire [1:0] reset_class_out,      // Last applied class
    output wire irq_out                     // Level interrupt
);

    // Masks port A bit 6 off when it is disabled or absent
    function [6:0] pa_mask;
        input [6:0] v;
        input en;
        begin
            pa_mask = {v[6] & en, v[5:0]};
        end
    endfunction

    // Address decode for the APB slave
    function addr_hit;
        input [7:0] a;
        begin
            case (a)
                `WRSI_ADDR_STATUS, `WRSI_ADDR_MASK, `WRSI_ADDR_CLASS,
                `WRSI_ADDR_TOS, `WRSI_ADDR_SPTR, `WRSI_ADDR_GIE,
                `WRSI_ADDR_PA_LATCH, `WRSI_ADDR_PA_DIR, `WRSI_ADDR_PA_PIN,
                `WRSI_ADDR_WAKE_FLAGS: addr_hit = 1'b1;
                default: addr_hit = 1'b0;
            endcase
        end
    endfunction

    reg emc_s1_r;                       // Pin sync stage 1
    reg emc_s2_r;                       // Pin sync stage 2
    reg [6:0] pa_s1_r;                  // Port sync stage 1
    reg [6:0] pa_s2_r;                  // Port sync stage 2
    reg [1:0] pend_class_r;             // Class awaiting release
    reg pend_irq_r;                     // Interrupt wake seen
    reg pend_hi_r;                      // High priority wake seen
    reg [SRC_W-1:0] pend_src_r;         // Sources seen during wake
    reg [1:0] class_r;                  // Last applied class
    reg [20:0] tos_r;                   // Stack top, 21 bits
    reg [4:0] sp_r;                     // Stack pointer count
    reg sp_full_r;                      // Stack full flag
    reg sp_unf_r;                       // Stack underflow flag
    reg [1:0] gie_r;                    // Global enables
    reg [6:0] pa_latch_r;               // Port A output latch
    reg [6:0] pa_dir_r;                 // Port A direction, 1 input
    reg [SRC_W:0] wake_flags_r;         // Wake flags, top is unknown
    reg [`WRSI_EV_W-1:0] status_r;      // Sticky event bits
    reg [`WRSI_EV_W-1:0] mask_r;        // Interrupt mask
    reg pc_load_r;                      // Vector load pulse
    reg [20:0] pc_value_r;              // Vector value
    reg [31:0] prdata_r;                // Registered read data
    reg [31:0] rd_nxt;                  // Read mux value
    reg [`WRSI_EV_W-1:0] ev_set;        // Events this cycle

    wire any_pwr;                       // Power class active
    wire any_ext;                       // External class active
    wire any_wake;                      // Wake class active
    wire any_active;                    // Any reset event held
    wire apply;                         // Release edge, apply class
    wire bit6_en;                       // Port A bit 6 usable
    wire wr_acc;                        // APB write access phase
    wire setup;                         // APB setup phase
    wire gie_any;                       // Either global enable
    wire [SRC_W:0] wake_src;            // Flags to set at wake
    wire [7:0] sp_read;                 // Stack pointer as read

    // Two-flop synchronisers for asynchronous pins
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            emc_s1_r <= 1'b1;
            emc_s2_r <= 1'b1;
            pa_s1_r <= 7'h00;
            pa_s2_r <= 7'h00;
        end else begin
            emc_s1_r <= ext_master_clear_n_in;
            emc_s2_r <= emc_s1_r;
            pa_s1_r <= port_a_pin_in;
            pa_s2_r <= pa_s1_r;
        end
    end

    assign any_pwr = power_on_rst_in | brown_out_rst_in;
    assign any_ext = ~emc_s2_r | watchdog_rst_in | reset_instr_in |
                     stack_rst_in;
    assign any_wake = wake_watchdog_in | wake_irq_in;
    assign any_active = any_pwr | any_ext | any_wake;
    assign apply = ~any_active & (pend_class_r != `WRSI_CLASS_NONE);
    assign gie_any = gie_r[`WRSI_GIE_HIGH] | gie_r[`WRSI_GIE_LOW];
    assign wake_src = (pend_src_r != {SRC_W{1'b0}}) ?
                      {1'b0, pend_src_r} : {1'b1, {SRC_W{1'b0}}};
    assign bit6_en = (BIT6_PRESENT != 0) &&
                     ((osc_mode_in == `WRSI_OSC_EXT_IO) ||
                      (osc_mode_in == `WRSI_OSC_RC_IO));
    assign sp_read = {sp_full_r, sp_unf_r, 1'b0, sp_r};
    assign setup = psel_in & ~penable_in;
    assign wr_acc = psel_in & penable_in & pwrite_in & addr_hit(paddr_in);

    // Collects the highest priority class while events are held
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            pend_class_r <= `WRSI_CLASS_NONE;
            pend_irq_r <= 1'b0;
            pend_hi_r <= 1'b0;
            pend_src_r <= {SRC_W{1'b0}};
        end else if (any_active) begin
            if (any_pwr) begin
                pend_class_r <= `WRSI_CLASS_POWER;
            end else if (any_ext &&
                         pend_class_r != `WRSI_CLASS_POWER) begin
                pend_class_r <= `WRSI_CLASS_EXTERNAL;
            end else if (pend_class_r == `WRSI_CLASS_NONE) begin
                pend_class_r <= `WRSI_CLASS_WAKE;
            end
            if (wake_irq_in) begin
                pend_irq_r <= 1'b1;
                pend_hi_r <= pend_hi_r | wake_high_prio_in;
                pend_src_r <= pend_src_r | irq_src_in;
            end
        end else begin
            // Released: clear for the next event
            pend_class_r <= `WRSI_CLASS_NONE;
            pend_irq_r <= 1'b0;
            pend_hi_r <= 1'b0;
            pend_src_r <= {SRC_W{1'b0}};
        end
    end

    // Events that raise sticky status bits
    always @* begin
        ev_set = {`WRSI_EV_W{1'b0}};
        if (apply) begin
            case (pend_class_r)
                `WRSI_CLASS_POWER: ev_set[`WRSI_EV_POWER] = 1'b1;
                `WRSI_CLASS_EXTERNAL: ev_set[`WRSI_EV_EXTERNAL] = 1'b1;
                `WRSI_CLASS_WAKE: begin
                    ev_set[`WRSI_EV_WAKE] = 1'b1;
                    ev_set[`WRSI_EV_VECTOR] = pend_irq_r & gie_any;
                    ev_set[`WRSI_EV_STACK_FULL] = pend_irq_r & gie_any &
                        (sp_r == `WRSI_SPTR_TOP);
                end
                default: ev_set = {`WRSI_EV_W{1'b0}};
            endcase
        end
    end

    // Stack, vector and class state applied per reset class
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            class_r <= `WRSI_CLASS_POWER;
            tos_r <= 21'h000000;
            sp_r <= 5'h00;
            sp_full_r <= 1'b0;
            sp_unf_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_value_r <= 21'h000000;
        end else begin
            pc_load_r <= 1'b0;
            if (apply) begin
                class_r <= pend_class_r;
                case (pend_class_r)
                    // Power class clears the stack top, pointer and both pointer flags
                    `WRSI_CLASS_POWER: begin
                        tos_r <= 21'h000000;
                        sp_r <= 5'h00;
                        sp_full_r <= 1'b0;
                        sp_unf_r <= 1'b0;
                    end
                    // External class keeps the pointer flags
                    `WRSI_CLASS_EXTERNAL: begin
                        tos_r <= 21'h000000;
                        sp_r <= 5'h00;
                    end
                    `WRSI_CLASS_WAKE: begin
                        if (pend_irq_r && gie_any) begin
                            pc_load_r <= 1'b1;
                            pc_value_r <= pend_hi_r ? `WRSI_VEC_HIGH :
                                                      `WRSI_VEC_LOW;
                            tos_r <= pc_in;
                            sp_r <= sp_r + 5'h01;
                            if (sp_r == `WRSI_SPTR_TOP) begin
                                sp_full_r <= 1'b1;
                            end
                        end
                    end
                    default: class_r <= class_r;
                endcase
            end
        end
    end

    // Software registers; hardware class effects win over writes
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            gie_r <= 2'h0;
            pa_latch_r <= 7'h00;
            pa_dir_r <= `WRSI_PA_DIR_RST;
            mask_r <= {`WRSI_EV_W{1'b0}};
        end else begin
            if (wr_acc) begin
                case (paddr_in)
                    `WRSI_ADDR_MASK: mask_r <= pwdata_in[`WRSI_EV_W-1:0];
                    `WRSI_ADDR_GIE: gie_r <= pwdata_in[1:0];
                    `WRSI_ADDR_PA_LATCH: pa_latch_r <= pwdata_in[6:0];
                    `WRSI_ADDR_PA_DIR: pa_dir_r <= pwdata_in[6:0];
                    default: mask_r <= mask_r;
                endcase
            end
            if (apply && (pend_class_r == `WRSI_CLASS_POWER ||
                          pend_class_r == `WRSI_CLASS_EXTERNAL)) begin
                gie_r <= 2'h0;
                pa_latch_r <= 7'h00;
                pa_dir_r <= `WRSI_PA_DIR_RST;
            end
        end
    end

    // Sticky bits: write one clears, a set in the same cycle wins
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            status_r <= {`WRSI_EV_W{1'b0}};
            wake_flags_r <= {(SRC_W+1){1'b0}};
        end else begin
            status_r <= (status_r &
                ~((wr_acc && paddr_in == `WRSI_ADDR_STATUS) ?
                  pwdata_in[`WRSI_EV_W-1:0] : {`WRSI_EV_W{1'b0}})) |
                ev_set;
            if (apply && pend_class_r == `WRSI_CLASS_POWER) begin
                wake_flags_r <= {(SRC_W+1){1'b0}};
            end else begin
                wake_flags_r <= (wake_flags_r &
                    ~((wr_acc && paddr_in == `WRSI_ADDR_WAKE_FLAGS) ?
                      pwdata_in[SRC_W:0] : {(SRC_W+1){1'b0}})) |
                    ((apply && pend_class_r == `WRSI_CLASS_WAKE &&
                      pend_irq_r) ? wake_src : {(SRC_W+1){1'b0}});
            end
        end
    end

    // Read mux; reserved bits stay zero
    always @* begin
        rd_nxt = 32'h00000000;
        case (paddr_in)
            `WRSI_ADDR_STATUS: rd_nxt[`WRSI_EV_W-1:0] = status_r;
            `WRSI_ADDR_MASK: rd_nxt[`WRSI_EV_W-1:0] = mask_r;
            `WRSI_ADDR_CLASS: rd_nxt[1:0] = class_r;
            `WRSI_ADDR_TOS: rd_nxt[20:0] = tos_r;
            `WRSI_ADDR_SPTR: rd_nxt[7:0] = sp_read;
            `WRSI_ADDR_GIE: rd_nxt[1:0] = gie_r;
            `WRSI_ADDR_PA_LATCH: rd_nxt[6:0] = pa_mask(pa_latch_r, bit6_en);
            `WRSI_ADDR_PA_DIR: rd_nxt[6:0] = pa_mask(pa_dir_r, bit6_en);
            `WRSI_ADDR_PA_PIN: rd_nxt[6:0] = pa_mask(pa_s2_r, bit6_en);
            `WRSI_ADDR_WAKE_FLAGS: rd_nxt[SRC_W:0] = wake_flags_r;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // Read data captured in setup, so access needs no wait state
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_hit(paddr_in);
    assign pc_load_out = pc_load_r;
    assign pc_value_out = pc_value_r;
    assign stack_top_upper_byte_out = tos_r[20:16];
    assign stack_top_high_byte_out = tos_r[15:8];
    assign stack_top_low_byte_out = tos_r[7:0];
    assign return_stack_pointer_out = sp_read;
    assign peripheral_irq_flag_regs_out = wake_flags_r;
    assign high_low_gie_out = gie_r;
    assign port_a_output_latch_out = pa_mask(pa_latch_r, bit6_en);
    assign port_a_oe_n_out = {pa_dir_r[6] | ~bit6_en, pa_dir_r[5:0]};
    assign reset_class_out = class_r;
    assign irq_out = |(status_r & mask_r);

endmodule // wrsi_top

//--- verif/wrsi_checker.sv
// Port checker for the wake-up and reset state initialiser.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "wrsi_defines.vh"
module wrsi_checker #(
    parameter SRC_W = 8                           // Wake source count
) (
    input wire clock_in,                          // Core clock
    input wire sys_rst_in,                        // Sync reset
    input wire psel_in,                           // APB select
    input wire penable_in,                        // APB enable
    input wire [7:0] paddr_in,                    // APB address
    input wire pslverr_out,                       // APB error
    input wire power_on_rst_in,                   // Power-on event
    input wire brown_out_rst_in,                  // Brown-out event
    input wire ext_master_clear_n_in,             // Master clear pin
    input wire watchdog_rst_in,                   // Watchdog reset
    input wire reset_instr_in,                    // Reset instruction
    input wire stack_rst_in,                      // Stack reset
    input wire wake_watchdog_in,                  // Watchdog wake
    input wire wake_irq_in,                       // Interrupt wake
    input wire wake_high_prio_in,                 // High prio source
    input wire [20:0] pc_in,                      // Core PC
    input wire [3:0] osc_mode_in,                 // Oscillator mode
    input wire pc_load_out,                       // Vector load
    input wire [20:0] pc_value_out,               // Vector value
    input wire [4:0] stack_top_upper_byte_out,    // Stack top upper
    input wire [7:0] stack_top_high_byte_out,     // Stack top high
    input wire [7:0] stack_top_low_byte_out,      // Stack top low
    input wire [7:0] return_stack_pointer_out,    // Stack pointer
    input wire [SRC_W:0] peripheral_irq_flag_regs_out, // Wake flags
    input wire [1:0] high_low_gie_out,            // Global enables
    input wire [6:0] port_a_output_latch_out,     // Port A drive
    input wire [6:0] port_a_oe_n_out,             // Port A enable
    input wire [1:0] reset_class_out              // Applied class
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // All events idle; master clear held long enough to pass its sync
    sequence s_quiet;
        !power_on_rst_in && !brown_out_rst_in && !watchdog_rst_in &&
        !reset_instr_in && !stack_rst_in && !wake_watchdog_in &&
        !wake_irq_in && ext_master_clear_n_in &&
        $past(ext_master_clear_n_in) && $past(ext_master_clear_n_in, 2);
    endsequence
    // Interrupt wake followed by the apply edge
    sequence s_wake_apply;
        wake_irq_in ##1 s_quiet;
    endsequence
    a_load_on_wake: assert property (s_wake_apply ##0 (|high_low_gie_out)
        |=> pc_load_out) else $error("no vector load after wake");
    a_load_cause: assert property (pc_load_out |-> $past(wake_irq_in, 2))
        else $error("vector load without interrupt wake");
    a_load_once: assert property (pc_load_out |=> !pc_load_out)
        else $error("vector load longer than one cycle");
    a_load_vector: assert property (pc_load_out |-> pc_value_out ==
        ($past(wake_high_prio_in, 2) ? `WRSI_VEC_HIGH : `WRSI_VEC_LOW))
        else $error("wrong vector value");
    a_stack_top_pc: assert property (pc_load_out |-> {
        stack_top_upper_byte_out, stack_top_high_byte_out,
        stack_top_low_byte_out} == $past(pc_in))
        else $error("stack top not the saved PC");
    a_stack_ptr_step: assert property (pc_load_out |->
        return_stack_pointer_out[4:0] ==
        $past(return_stack_pointer_out[4:0]) + 5'h01)
        else $error("stack pointer not advanced by one");
    a_wake_flag_set: assert property (s_wake_apply
        |=> |peripheral_irq_flag_regs_out)
        else $error("no wake flag after interrupt wake");
    a_bit6_gated: assert property ($stable(osc_mode_in) &&
        osc_mode_in != `WRSI_OSC_EXT_IO && osc_mode_in != `WRSI_OSC_RC_IO
        |-> port_a_oe_n_out[6] && !port_a_output_latch_out[6])
        else $error("port A bit 6 active in wrong mode");
    a_ext_class: assert property (watchdog_rst_in && !power_on_rst_in &&
        !brown_out_rst_in ##1 s_quiet
        |=> reset_class_out == `WRSI_CLASS_EXTERNAL)
        else $error("watchdog reset not external class");
    a_unmapped_err: assert property (psel_in && penable_in &&
        paddr_in > `WRSI_ADDR_WAKE_FLAGS |-> pslverr_out)
        else $error("unmapped access not refused");
endmodule // wrsi_checker
bind wrsi_top wrsi_checker #(.SRC_W(SRC_W)) i_chk (.*);

//--- verif/wrsi_core_model.sv
// Core-side model: PC that sleeps and jumps on a vector load, and
// port A pads with pull-ups wherever the block is not driving.
`timescale 1ns/1ps
module wrsi_core_model #(
    parameter PC_RST = 21'h000100       // PC held while asleep
) (
    input wire clock_in,                // Core clock
    input wire sys_rst_in,              // Sync reset
    input wire pc_load_in,              // Vector load pulse
    input wire [20:0] pc_value_in,      // Vector value
    input wire [6:0] latch_in,          // Port A drive value
    input wire [6:0] oe_n_in,           // Port A enable, low
    output reg [20:0] pc_out,           // Current PC
    output wire [6:0] pin_out           // Port A pad levels
);
    // Asleep core never steps, so only a vector load moves the PC
    always @(posedge clock_in) begin
        if (sys_rst_in)
            pc_out <= PC_RST;
        else if (pc_load_in)
            pc_out <= pc_value_in;
    end
    // Undriven pads float to the pull-up, never the last value
    assign pin_out = (latch_in & ~oe_n_in) | oe_n_in;
endmodule // wrsi_core_model

//--- verif/wrsi_top_tb.sv
// Testbench for wrsi_top: APB register tests and event pulses.
// Assumes the core model on the PC and port A pins.
`timescale 1ns/1ps
`include "wrsi_defines.vh"
module wrsi_top_tb;
    localparam SRC_W = 8;               // Wake source count
    logic clock_in = 1'b0;              // Core clock
    logic sys_rst_in = 1'b1;            // Sync reset
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;       // APB address
    logic [31:0] pwdata_in = 32'h00000000, prdata_out;
    logic pready_out, pslverr_out, pc_load_out, irq_out;
    logic [8:0] ev = 9'h000;            // Events, see port map
    logic [SRC_W-1:0] src = 8'h00;      // Pending sources
    logic [3:0] osc = 4'h0;             // Oscillator mode
    logic [20:0] pc, pc_value_out;
    logic [6:0] pins, latch, oe_n;
    logic [1:0] cls;
    logic [31:0] rd;                    // Last read data
    logic er;                           // Last error flag
    logic en6;                          // Bit 6 expected live
    integer failures = 0, cmp_count = 0, loads = 0, m;
    always #2.5 clock_in = ~clock_in;
    wrsi_top #(.SRC_W(SRC_W), .BIT6_PRESENT(1)) i_dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .power_on_rst_in(ev[0]),
        .brown_out_rst_in(ev[1]), .ext_master_clear_n_in(~ev[2]),
        .watchdog_rst_in(ev[3]), .reset_instr_in(ev[4]),
        .stack_rst_in(ev[5]), .wake_watchdog_in(ev[6]),
        .wake_irq_in(ev[7]), .wake_high_prio_in(ev[8]),
        .irq_src_in(src), .pc_in(pc), .osc_mode_in(osc),
        .port_a_pin_in(pins), .pc_load_out(pc_load_out),
        .pc_value_out(pc_value_out), .stack_top_upper_byte_out(),
        .stack_top_high_byte_out(), .stack_top_low_byte_out(),
        .return_stack_pointer_out(), .peripheral_irq_flag_regs_out(),
        .high_low_gie_out(), .port_a_output_latch_out(latch),
        .port_a_oe_n_out(oe_n), .reset_class_out(cls), .irq_out(irq_out));
    wrsi_core_model i_core (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .pc_load_in(pc_load_out), .pc_value_in(pc_value_out),
        .latch_in(latch), .oe_n_in(oe_n), .pc_out(pc), .pin_out(pins));
    // Count vector loads seen by the core
    always @(posedge clock_in) if (pc_load_out === 1'b1) loads <= loads + 1;
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; waits on pready under a bound
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer i;
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        i = 0;
        do begin
            @(posedge clock_in);
            i = i + 1;
        end while (pready_out !== 1'b1 && i < 20);
        if (pready_out !== 1'b1) begin
            failures = failures + 1;
            conclude();
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask
    // One-cycle event pulse, then time for sync and apply
    task pulse(input logic [8:0] e);
        @(posedge clock_in);
        ev <= e;
        @(posedge clock_in);
        ev <= 9'h000;
        repeat (5) @(posedge clock_in);
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rchk("class", `WRSI_ADDR_CLASS, 32'h00000001);
        rchk("dir", `WRSI_ADDR_PA_DIR, 32'h0000003F);
        apb(1'b1, `WRSI_ADDR_CLASS, 32'h00000003);
        rchk("class ro", `WRSI_ADDR_CLASS, 32'h00000001);
        apb(1'b0, 8'h28, 32'h00000000);
        chk("unmapped err", 32'h00000001, {31'h0, er});
        chk("unmapped rd", 32'h00000000, rd);
        apb(1'b1, `WRSI_ADDR_MASK, 32'hFFFFFFE4);
        rchk("mask", `WRSI_ADDR_MASK, 32'h00000004);
        $display("test regs done");
        apb(1'b1, `WRSI_ADDR_PA_LATCH, 32'h0000007F);
        apb(1'b1, `WRSI_ADDR_PA_DIR, 32'h00000000);
        for (m = 0; m < 16; m = m + 1) begin
            osc <= m[3:0];
            repeat (3) @(posedge clock_in);
            en6 = m == `WRSI_OSC_EXT_IO || m == `WRSI_OSC_RC_IO;
            rchk("latch", `WRSI_ADDR_PA_LATCH, en6 ? 32'h7F : 32'h3F);
            rchk("pin", `WRSI_ADDR_PA_PIN, en6 ? 32'h7F : 32'h3F);
        end
        $display("test port a done");
        apb(1'b1, `WRSI_ADDR_GIE, 32'h00000001);
        src <= 8'h04;
        pulse(9'h180);
        chk("pc", 32'h8, {11'h0, pc});
        rchk("tos", `WRSI_ADDR_TOS, 32'h00000100);
        rchk("ptr", `WRSI_ADDR_SPTR, 32'h00000001);
        rchk("flags", `WRSI_ADDR_WAKE_FLAGS, 32'h00000004);
        chk("irq set", 32'h1, {31'h0, irq_out});
        apb(1'b1, `WRSI_ADDR_STATUS, 32'h0000001F);
        @(posedge clock_in);
        chk("irq clear", 32'h0, {31'h0, irq_out});
        apb(1'b1, `WRSI_ADDR_WAKE_FLAGS, 32'h000001FF);
        apb(1'b1, `WRSI_ADDR_GIE, 32'h00000002);
        src <= 8'h00;
        pulse(9'h080);
        chk("pc low", 32'h18, {11'h0, pc});
        rchk("tos 2", `WRSI_ADDR_TOS, 32'h00000008);
        rchk("ptr 2", `WRSI_ADDR_SPTR, 32'h00000002);
        rchk("flag top", `WRSI_ADDR_WAKE_FLAGS, 32'h1 << SRC_W);
        $display("test irq wake done");
        apb(1'b1, `WRSI_ADDR_GIE, 32'h00000000);
        pulse(9'h040);
        chk("loads", 32'h2, loads);
        chk("wake class", `WRSI_CLASS_WAKE, {30'h0, cls});
        rchk("ptr kept", `WRSI_ADDR_SPTR, 32'h00000002);
        $display("test plain wake done");
        for (m = 0; m < 6; m = m + 1) begin
            pulse(9'h001 << m);
            chk("class", m < 2 ? 32'h1 : 32'h2, {30'h0, cls});
            rchk("ptr zero", `WRSI_ADDR_SPTR, 32'h00000000);
        end
        $display("test reset classes done");
        conclude();
    end
endmodule // wrsi_top_tb
